// ==== rla_lookup_ram_access.sv ====
// design: register access port to the clock lookup ram
//
// Decided for this implementation: strobed register access.
`default_nettype none
module rla_lookup_ram_access #(
	parameter int ACCESS_CYC = rla_pkg::ACCESS_CYC
) (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire rla_pkg::rla_req_t req,
	output var  logic [7:0]        rdata,
	output var  logic              busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------
	// reset release
	// ---------------------------------------------
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ---------------------------------------------
	// registers and ram
	// ---------------------------------------------
	logic [rla_pkg::PTR_W-1:0] ptr_q;
	logic                      auto_q;
	logic [7:0]                data_q;
	logic                      wr_stb_q;
	logic                      rd_stb_q;
	logic [3:0]                cnt_q;
	logic [7:0]                ram_q [rla_pkg::RAM_DEPTH];
	logic                      done;
	logic                      active;

	assign active = wr_stb_q | rd_stb_q;
	assign done   = active && (cnt_q == 4'(ACCESS_CYC - 1));

	// access timer
	always_ff @(posedge mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			cnt_q <= 4'h0;
		else if (active && !done)
			cnt_q <= cnt_q + 4'h1;
		else
			cnt_q <= 4'h0;
	end

	// strobes
	always_ff @(posedge mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
		end
		else if (done)
		begin
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
		end
		else if (req.wr && req.addr == rla_pkg::ADDR_STROBES && !active)
		begin
			wr_stb_q <= req.wdata[rla_pkg::WR_BIT];
			rd_stb_q <= req.wdata[rla_pkg::RD_BIT] & ~req.wdata[rla_pkg::WR_BIT];
		end
	end

	// pointer and auto step
	always_ff @(posedge mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ptr_q  <= '0;
			auto_q <= 1'b0;
		end
		else if (done)
		begin
			if (auto_q)
				ptr_q <= ptr_q + 7'h01;
		end
		else if (req.wr && req.addr == rla_pkg::ADDR_PTR)
		begin
			ptr_q  <= req.wdata[rla_pkg::PTR_W-1:0];
			auto_q <= req.wdata[rla_pkg::AUTO_BIT];
		end
	end

	// data byte
	always_ff @(posedge mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			data_q <= rla_pkg::RESET_BYTE;
		else if (done && rd_stb_q)
			data_q <= ram_q[ptr_q];
		else if (req.wr && req.addr == rla_pkg::ADDR_DATA && !active)
			data_q <= req.wdata;
	end

	// lookup ram
	always_ff @(posedge mclk)
	begin
		if (done && wr_stb_q)
			ram_q[ptr_q] <= data_q;
	end

	// ---------------------------------------------
	// read port
	// ---------------------------------------------
	always_ff @(posedge mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			rdata <= 8'h00;
			busy  <= 1'b0;
		end
		else
		begin
			busy <= active && !done;
			if (req.rd)
			begin
				unique case (req.addr)
					rla_pkg::ADDR_PTR:     rdata <= {auto_q, ptr_q};
					rla_pkg::ADDR_DATA:    rdata <= data_q;
					rla_pkg::ADDR_STROBES: rdata <= {6'h00, rd_stb_q, wr_stb_q};
					default:               rdata <= 8'h00;
				endcase
			end
			else
				rdata <= 8'h00;
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	// cycles a strobe has stood, kept apart from the access timer so the checks
	// follow any access length
	logic [4:0] hold_cnt_q;
	always_ff @(posedge mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			hold_cnt_q <= 5'h00;
		else if (active)
			hold_cnt_q <= hold_cnt_q + 5'h01;
		else
			hold_cnt_q <= 5'h00;
	end

	AST_STROBE_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n_q)
		$fell(wr_stb_q) |-> hold_cnt_q == 5'(ACCESS_CYC))
		else $error("write strobe not held for access");
	AST_RD_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n_q)
		$fell(rd_stb_q) |-> hold_cnt_q == 5'(ACCESS_CYC))
		else $error("read strobe not held for access");
	AST_STROBE_BOUND: assert property (@(posedge mclk) disable iff (!rst_n_q)
		active |-> hold_cnt_q < 5'(ACCESS_CYC))
		else $error("strobe held past access");
	AST_STEP: assert property (@(posedge mclk) disable iff (!rst_n_q)
		done && auto_q |=> ptr_q == $past(ptr_q) + 7'h01)
		else $error("pointer did not step");
	AST_NO_STEP: assert property (@(posedge mclk) disable iff (!rst_n_q)
		done && !auto_q |=> ptr_q == $past(ptr_q))
		else $error("pointer moved without auto step");
	AST_READ_FETCH: assert property (@(posedge mclk) disable iff (!rst_n_q)
		done && rd_stb_q |=> data_q == ram_q[$past(ptr_q)])
		else $error("read did not fetch ram byte");
	AST_LAUNCH: assert property (@(posedge mclk) disable iff (!rst_n_q)
		req.wr && req.addr == rla_pkg::ADDR_STROBES && !active && req.wdata[0]
		|=> wr_stb_q)
		else $error("write strobe not launched");
	AST_PTR_WRITE: assert property (@(posedge mclk) disable iff (!rst_n_q)
		req.wr && req.addr == rla_pkg::ADDR_PTR && !done
		|=> ptr_q == $past(req.wdata[6:0]) && auto_q == $past(req.wdata[7]))
		else $error("pointer write lost");
	AST_DATA_WRITE: assert property (@(posedge mclk) disable iff (!rst_n_q)
		req.wr && req.addr == rla_pkg::ADDR_DATA && !active |=> data_q == $past(req.wdata))
		else $error("data write lost");
	AST_RD_LAUNCH: assert property (@(posedge mclk) disable iff (!rst_n_q)
		req.wr && req.addr == rla_pkg::ADDR_STROBES && !active
		&& req.wdata[rla_pkg::RD_BIT] && !req.wdata[rla_pkg::WR_BIT] |=> rd_stb_q)
		else $error("read strobe not launched");
	AST_WRITE_STORE: assert property (@(posedge mclk) disable iff (!rst_n_q)
		done && wr_stb_q |=> ram_q[$past(ptr_q)] == $past(data_q))
		else $error("write did not store data byte");
	AST_ONE_STROBE: assert property (@(posedge mclk) disable iff (!rst_n_q)
		!(wr_stb_q && rd_stb_q))
		else $error("both strobes set");
	AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rst_n_q)
		!req.rd |=> rdata == 8'h00)
		else $error("read data not idle");
	AST_BUSY: assert property (@(posedge mclk) disable iff (!rst_n_q)
		busy |-> active)
		else $error("busy without strobe");
	AST_DATA_READ: assert property (@(posedge mclk) disable iff (!rst_n_q)
		req.rd && req.addr == rla_pkg::ADDR_DATA |=> rdata == $past(data_q))
		else $error("data read wrong");
	AST_PTR_READ: assert property (@(posedge mclk) disable iff (!rst_n_q)
		req.rd && req.addr == rla_pkg::ADDR_PTR |=> rdata == {$past(auto_q), $past(ptr_q)})
		else $error("pointer read wrong");
	AST_STROBE_READ: assert property (@(posedge mclk) disable iff (!rst_n_q)
		req.rd && req.addr == rla_pkg::ADDR_STROBES
		|=> rdata == {6'h00, $past(rd_stb_q), $past(wr_stb_q)})
		else $error("strobe read wrong");
endmodule
`default_nettype wire

// ==== rla_pkg.sv ====
// package: register map, field layout and timing constants for the lookup ram access port
`default_nettype none
package rla_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] ADDR_PTR     = 16'h2887;
	localparam logic [15:0] ADDR_DATA    = 16'h2888;
	localparam logic [15:0] ADDR_STROBES = 16'h2889;
	localparam int          PTR_W        = 7;
	localparam int          AUTO_BIT     = 7;
	localparam int          WR_BIT       = 0;
	localparam int          RD_BIT       = 1;
	localparam logic [7:0]  RESET_BYTE   = 8'h00;
	localparam int          RAM_DEPTH    = 128;
	localparam int          ACCESS_CYC   = 2;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} rla_req_t;
endpackage
`default_nettype wire

// ==== rla_tb.sv ====
// testbench: register level tests of the lookup ram access port
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD %s expected %h seen %h", n, e, a); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] a_p = rla_pkg::ADDR_PTR;
	localparam logic [15:0] a_d = rla_pkg::ADDR_DATA;
	localparam logic [15:0] a_s = rla_pkg::ADDR_STROBES;
	logic              mclk = 1'b0;
	logic              resetn = 1'b0;
	rla_pkg::rla_req_t req = '0;
	logic [7:0]        rdata;
	logic              busy;
	logic [7:0]        v;
	int                fail_count = 0;
	int                checks = 0;
	int                cyc = 0;
	always #2 mclk = ~mclk;
	rla_lookup_ram_access #(.ACCESS_CYC(6)) DUT (.mclk(mclk), .resetn(resetn), .req(req),
		.rdata(rdata), .busy(busy));
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk) req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk) req.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk_rd(input logic [15:0] a, input logic [7:0] e, input string n);
		rd(a, v);
		`CHK(n, e, v)
	endtask
	task automatic op(input logic [7:0] s, input logic [7:0] e);
		wr(a_s, s);
		chk_rd(a_s, e, "held");
		`CHK("busy", 1'b1, busy)
		for (int i = 0; i < 20 && v !== 8'h00; i++)
			rd(a_s, v);
		`CHK("clear", 8'h00, v)
		`CHK("idle", 1'b0, busy)
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		chk_rd(a_p, 8'h00, "ptr");
		chk_rd(a_d, 8'h00, "data");
		chk_rd(a_s, 8'h00, "strobes");
		chk_rd(16'h2890, 8'h00, "unmapped");
		$display("test reset done");
		wr(a_p, 8'h05);
		wr(a_d, 8'hA5);
		op(8'h01, 8'h01);
		chk_rd(a_p, 8'h05, "ptr kept");
		wr(a_p, 8'h86);
		wr(a_d, 8'h3C);
		op(8'h01, 8'h01);
		chk_rd(a_p, 8'h87, "ptr step");
		wr(a_p, 8'hFF);
		wr(a_d, 8'h11);
		op(8'h03, 8'h01);
		chk_rd(a_p, 8'h80, "ptr wrap");
		$display("test write done");
		wr(a_p, 8'h05);
		op(8'h02, 8'h02);
		chk_rd(a_d, 8'hA5, "read 5");
		chk_rd(a_p, 8'h05, "ptr kept");
		wr(a_p, 8'h86);
		op(8'h02, 8'h02);
		chk_rd(a_d, 8'h3C, "read 6");
		chk_rd(a_p, 8'h87, "ptr step");
		wr(a_p, 8'h7F);
		op(8'h02, 8'h02);
		chk_rd(a_d, 8'h11, "read 127");
		$display("test read done");
		print_verdict();
	end
endmodule
`default_nettype wire
